/* tb/ssp_host_model.sv */
// Purpose: Host master model driving the sensor serial port
// Assumes: SCLK idles high, half period of 8 core cycles
// Notes: MOSI toggles while deselected so a stale level never helps
`timescale 1ns/10ps
module ssp_host_model (
  input wire logic core_clk,
  output logic sel_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  logic junk_clk;
  int hold_bad;

  initial
  begin
    sel_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
    junk_clk = 1'b0;
    hold_bad = 0;
  end

  // Released line; junk clocks only when a scenario asks
  always @(posedge core_clk)
  begin
    if (sel_n)
    begin
      mosi <= ~mosi;
      if (junk_clk)
        sclk <= ~sclk;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Every transaction framed by select, clock parked high
  task automatic frame(input logic on);
    sclk <= 1'b1;
    cyc(20);
    sel_n <= ~on;
    cyc(20);
  endtask

  // MSB first, fall then rise, high phase a full half period
  task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      sclk <= 1'b0;
      mosi <= tx[i];
      cyc(8);
      rx[i] = miso_oe ? miso : 1'bz;
      sclk <= 1'b1;
      cyc(8);
      if ((miso_oe ? miso : 1'bz) !== rx[i])
        hold_bad++;
    end
  endtask
endmodule

/* tb/ssp_slave_tb.sv */
// Purpose: Self-checking bench for the serial port slave
// Assumes: Short downshift counts; SCLK period 160 ns
// Notes: Bench plays the register core behind reg_req
`timescale 1ns/10ps
module ssp_slave_tb;
  logic core_clk, rst, mot_evt, sel_n, sclk, mosi, miso, miso_oe, motion_n, led_on;
  logic [7:0] reg_rdata, rx;
  ssp_pkg::ssp_req_t reg_req, last_req;
  ssp_pkg::ssp_pwr_t pwr_mode;
  int error_cnt, n_tests, n_req, cycles, n0;

  ssp_slave #(.DOWN1(100), .DOWN2(200), .DOWN3(400)) ssp_slave_i (
    .core_clk(core_clk), .rst(rst), .sel_n(sel_n), .sclk(sclk), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .mot_evt(mot_evt), .motion_n(motion_n), .pwr_mode(pwr_mode), .led_on(led_on));

  ssp_host_model ssp_host_model_i (
    .core_clk(core_clk), .sel_n(sel_n), .sclk(sclk), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe));

  function automatic logic [7:0] rdata_of(input logic [6:0] a);
    return {a, 1'b1} ^ 8'hA5;
  endfunction

  task automatic report_and_stop();
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Register core: data one cycle after a read request
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (reg_req.wr || reg_req.rd)
    begin
      n_req <= n_req + 1;
      last_req <= reg_req;
    end
    if (reg_req.rd)
      reg_rdata <= rdata_of(reg_req.addr);
    if (cycles == 60000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  // Write-write and write-read spacing, hold before deselect
  task automatic do_write(input logic [6:0] a, input logic [7:0] d);
    ssp_host_model_i.frame(1'b1);
    ssp_host_model_i.shift({ssp_pkg::DIR_WRITE, a}, 8, rx);
    ssp_host_model_i.shift(d, 8, rx);
    ssp_host_model_i.cyc(2000);
    ssp_host_model_i.frame(1'b0);
    ssp_host_model_i.cyc(1000);
  endtask

  // Fetch pause and read-to-next spacing
  task automatic do_read(input logic [6:0] a, output logic [7:0] d);
    ssp_host_model_i.frame(1'b1);
    ssp_host_model_i.shift({1'b0, a}, 8, rx);
    ssp_host_model_i.cyc(400);
    ssp_host_model_i.shift(8'h00, 8, d);
    ssp_host_model_i.frame(1'b0);
    ssp_host_model_i.cyc(60);
  endtask

  task automatic pulse_motion();
    mot_evt <= 1'b1;
    @(posedge core_clk);
    mot_evt <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic test_write();
    n0 = n_req;
    do_write(7'h11, 8'h3C);
    check(16'(n_req - n0), 16'h0001);
    check({last_req.wr, last_req.addr, last_req.data}, {1'b1, 7'h11, 8'h3C});
    check({15'h0000, miso_oe}, 16'h0000);
  endtask

  task automatic test_read();
    logic [6:0] addrs[2];
    addrs = '{7'h15, 7'h7F};
    foreach (addrs[k])
    begin
      do_read(addrs[k], rx);
      check({8'h00, rx}, {8'h00, rdata_of(addrs[k])});
      check({last_req.rd, last_req.addr}, {1'b1, addrs[k]});
    end
    check(16'(ssp_host_model_i.hold_bad), 16'h0000);
  endtask

  task automatic test_motion();
    pulse_motion();
    check({15'h0000, motion_n}, 16'h0000);
    do_read(ssp_pkg::ADDR_DELTA_Y, rx);
    check({15'h0000, motion_n}, 16'h0000);
    do_read(ssp_pkg::ADDR_DELTA_X, rx);
    check({15'h0000, motion_n}, 16'h0001);
    pulse_motion();
    do_write(ssp_pkg::ADDR_MOTION, 8'h00);
    check({15'h0000, motion_n}, 16'h0001);
  endtask

  // Junk while deselected, then a write cut off mid data byte
  task automatic test_abort();
    n0 = n_req;
    ssp_host_model_i.junk_clk <= 1'b1;
    ssp_host_model_i.cyc(200);
    ssp_host_model_i.junk_clk <= 1'b0;
    ssp_host_model_i.cyc(2);
    check({15'h0000, miso_oe}, 16'h0000);
    ssp_host_model_i.frame(1'b1);
    ssp_host_model_i.shift(8'hB3, 8, rx);
    ssp_host_model_i.shift(8'h5A, 5, rx);
    ssp_host_model_i.frame(1'b0);
    ssp_host_model_i.cyc(3000);
    check(16'(n_req - n0), 16'h0000);
    do_write(7'h33, 8'h96);
    check(16'(n_req - n0), 16'h0001);
    check({last_req.wr, last_req.addr, last_req.data}, {1'b1, 7'h33, 8'h96});
  endtask

  task automatic test_burst();
    ssp_host_model_i.frame(1'b1);
    ssp_host_model_i.shift({1'b0, ssp_pkg::ADDR_BURST}, 8, rx);
    ssp_host_model_i.cyc(400);
    for (int i = 0; i < 7; i++)
    begin
      ssp_host_model_i.shift(8'h00, 8, rx);
      check({8'h00, rx}, {8'h00, rdata_of(ssp_pkg::ADDR_BURST_FIRST + 7'(i))});
    end
    n0 = n_req;
    ssp_host_model_i.shift(8'h91, 8, rx);
    ssp_host_model_i.shift(8'h77, 8, rx);
    ssp_host_model_i.cyc(2000);
    check(16'(n_req - n0), 16'h0000);
    ssp_host_model_i.frame(1'b0);
    ssp_host_model_i.cyc(1000);
    do_write(7'h12, 8'h34);
    check({last_req.wr, last_req.addr, last_req.data}, {1'b1, 7'h12, 8'h34});
  endtask

  task automatic test_power();
    int cnt;
    pulse_motion();
    ssp_host_model_i.cyc(46);
    check(16'(pwr_mode), 16'(ssp_pkg::SSP_PWR_RUN));
    ssp_host_model_i.cyc(100);
    check(16'(pwr_mode), 16'(ssp_pkg::SSP_PWR_REST1));
    ssp_host_model_i.cyc(150);
    check(16'(pwr_mode), 16'(ssp_pkg::SSP_PWR_REST2));
    ssp_host_model_i.cyc(200);
    check(16'(pwr_mode), 16'(ssp_pkg::SSP_PWR_REST3));
    cnt = 0;
    // Motion kept coming so the frame rate stays at its fastest
    for (int i = 0; i < 1024; i++)
    begin
      mot_evt <= (i % 40 == 0);
      @(posedge core_clk);
      cnt += int'(led_on === 1'b1);
    end
    mot_evt <= 1'b0;
    check({15'h0000, cnt inside {[1:32]}}, 16'h0001);
  endtask

  initial
  begin
    rst = 1'b1;
    mot_evt = 1'b0;
    reg_rdata = 8'h00;
    error_cnt = 0;
    n_tests = 0;
    n_req = 0;
    cycles = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    check({15'h0000, motion_n}, 16'h0001);
    test_write();
    test_read();
    test_motion();
    test_abort();
    test_burst();
    test_power();
    report_and_stop();
  end
endmodule

/* verilog/ssp_pkg.sv */
// Purpose: Shared constants and types for the sensor serial port slave
// Assumes: 100 MHz core clock; host link sampled, not clocked
// Notes: The longest downshift count (DOWN3_CYC) exceeds 32 bits, so they are longint
package ssp_pkg;

  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_CNT_W = 3;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int DIR_BIT = 7;
  localparam logic DIR_WRITE = 1'b1;

  localparam logic [6:0] ADDR_MOTION = 7'h02;
  localparam logic [6:0] ADDR_DELTA_Y = 7'h03;
  localparam logic [6:0] ADDR_DELTA_X = 7'h04;
  localparam logic [6:0] ADDR_BURST = 7'h42;
  // Burst streams consecutive addresses from the motion register on
  localparam logic [6:0] ADDR_BURST_FIRST = 7'h02;
  localparam logic [2:0] BURST_LAST = 3'h6;

  localparam real CLK_HZ = 100.0e6;
  localparam real T_DOWN1_S = 0.237;
  localparam real T_DOWN2_S = 8.4;
  localparam real T_DOWN3_S = 504.0;
  localparam longint DOWN1_CYC = longint'(T_DOWN1_S * CLK_HZ);
  localparam longint DOWN2_CYC = longint'(T_DOWN2_S * CLK_HZ);
  localparam longint DOWN3_CYC = longint'(T_DOWN3_S * CLK_HZ);
  localparam int IDLE_CNT_W = 40;

  localparam int FRAME_CNT_W = 24;

  typedef enum {SSP_ST_ADDR, SSP_ST_WDATA, SSP_ST_RDATA, SSP_ST_LOCK} ssp_state_t;
  typedef enum {SSP_PWR_RUN, SSP_PWR_REST1, SSP_PWR_REST2, SSP_PWR_REST3} ssp_pwr_t;

  typedef struct packed {
    logic ncs;
    logic sclk;
    logic mosi;
  } ssp_pins_t;

  // Clock parked high like an idle host, so no false edge follows reset
  localparam ssp_pins_t PINS_IDLE = '{ncs: 1'b1, sclk: 1'b1, mosi: 1'b0};

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] data;
  } ssp_req_t;

endpackage

/* verilog/ssp_pwr_mgr.sv */
// Purpose: Power-mode downshift timer and frame-gated LED pulses
// Assumes: mot_evt is a one-cycle pulse on core_clk
// Notes: Frame periods per mode are plain defaults
`timescale 1ns/10ps
module ssp_pwr_mgr #(
  parameter longint DOWN1 = ssp_pkg::DOWN1_CYC,
  parameter longint DOWN2 = ssp_pkg::DOWN2_CYC,
  parameter longint DOWN3 = ssp_pkg::DOWN3_CYC,
  parameter logic [23:0] FRAME_RUN = 24'h000400,
  parameter logic [23:0] FRAME_REST1 = 24'h004000,
  parameter logic [23:0] FRAME_REST2 = 24'h040000,
  parameter logic [23:0] FRAME_REST3 = 24'h400000,
  parameter logic [23:0] LED_ON_CYC = 24'h000010
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic mot_evt,
  output ssp_pkg::ssp_pwr_t pwr_mode,
  output logic led_on
);

  logic [ssp_pkg::IDLE_CNT_W-1:0] idle_r;
  logic [ssp_pkg::FRAME_CNT_W-1:0] frame_r;
  logic [ssp_pkg::FRAME_CNT_W-1:0] period;
  ssp_pkg::ssp_pwr_t mode_r;

  // Motion restarts the idle clock and returns to full rate
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      idle_r <= '0;
      mode_r <= ssp_pkg::SSP_PWR_RUN;
    end
    else if (mot_evt)
    begin
      idle_r <= '0;
      mode_r <= ssp_pkg::SSP_PWR_RUN;
    end
    else
    begin
      if (idle_r != DOWN3[ssp_pkg::IDLE_CNT_W-1:0])
        idle_r <= idle_r + 1'b1;
      if (idle_r == DOWN3[ssp_pkg::IDLE_CNT_W-1:0])
        mode_r <= ssp_pkg::SSP_PWR_REST3;
      else if (idle_r == DOWN2[ssp_pkg::IDLE_CNT_W-1:0])
        mode_r <= ssp_pkg::SSP_PWR_REST2;
      else if (idle_r == DOWN1[ssp_pkg::IDLE_CNT_W-1:0])
        mode_r <= ssp_pkg::SSP_PWR_REST1;
    end
  end

  always_comb
  begin
    case (mode_r)
      ssp_pkg::SSP_PWR_RUN: period = FRAME_RUN;
      ssp_pkg::SSP_PWR_REST1: period = FRAME_REST1;
      ssp_pkg::SSP_PWR_REST2: period = FRAME_REST2;
      default: period = FRAME_REST3;
    endcase
  end

  // LED lit only for the exposure window at the start of each frame
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      frame_r <= '0;
      led_on <= 1'b0;
    end
    else
    begin
      frame_r <= (frame_r >= period - 1'b1) ? '0 : frame_r + 1'b1;
      led_on <= (frame_r < LED_ON_CYC);
    end
  end

  assign pwr_mode = mode_r;

  chk_motion_run: assert property (@(posedge core_clk) disable iff (rst)
    mot_evt |=> (pwr_mode == ssp_pkg::SSP_PWR_RUN) && (idle_r == '0))
    else $error("Motion did not return to run mode");

  chk_led_gated: assert property (@(posedge core_clk) disable iff (rst)
    led_on |-> $past(frame_r) < LED_ON_CYC)
    else $error("LED lit outside exposure window");

endmodule

/* verilog/ssp_slave.sv */
// Purpose: Serial port slave, motion alert and power management top
// Assumes: Host pins are asynchronous; core answers reads one cycle later
// Notes: SCLK must stay well below a quarter of core_clk
`timescale 1ns/10ps
module ssp_slave #(
  parameter longint DOWN1 = ssp_pkg::DOWN1_CYC,
  parameter longint DOWN2 = ssp_pkg::DOWN2_CYC,
  parameter longint DOWN3 = ssp_pkg::DOWN3_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  output ssp_pkg::ssp_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic mot_evt,
  output logic motion_n,
  output ssp_pkg::ssp_pwr_t pwr_mode,
  output logic led_on
);

  ssp_pkg::ssp_pins_t pins_m, pins_s;
  logic sclk_d, sclk_rise, sclk_fall, desel, byte_done;
  logic [7:0] rx_byte, rx_sh_r, tx_sh_r;
  logic [2:0] bit_cnt_r, bcnt_r;
  logic [6:0] addr_r;
  logic burst_r, load_r, miso_r;
  ssp_pkg::ssp_state_t st_r;
  ssp_pkg::ssp_req_t req_r;
  logic motion_n_r, rd_y_r, rd_x_r;
  logic y_now, x_now, wr_mot, mot_clr;

  // Two stages before any use; only the second stage is read
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pins_m <= ssp_pkg::PINS_IDLE;
      pins_s <= ssp_pkg::PINS_IDLE;
      sclk_d <= ssp_pkg::PINS_IDLE.sclk;
    end
    else
    begin
      pins_m <= '{ncs: sel_n, sclk: sclk, mosi: mosi};
      pins_s <= pins_m;
      sclk_d <= pins_s.sclk;
    end
  end

  assign desel = pins_s.ncs;
  // Edges count only while selected
  assign sclk_rise = !desel && pins_s.sclk && !sclk_d;
  assign sclk_fall = !desel && !pins_s.sclk && sclk_d;
  assign byte_done = sclk_rise && (bit_cnt_r == ssp_pkg::BIT_LAST) &&
                     (st_r != ssp_pkg::SSP_ST_LOCK);
  assign rx_byte = {rx_sh_r[6:0], pins_s.mosi};

  // Transaction sequencing
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= ssp_pkg::SSP_ST_ADDR;
      bit_cnt_r <= '0;
      rx_sh_r <= '0;
      addr_r <= '0;
      burst_r <= 1'b0;
      bcnt_r <= '0;
    end
    else if (desel)
    begin
      st_r <= ssp_pkg::SSP_ST_ADDR;
      bit_cnt_r <= '0;
      burst_r <= 1'b0;
      bcnt_r <= '0;
    end
    else if (sclk_rise && st_r != ssp_pkg::SSP_ST_LOCK)
    begin
      bit_cnt_r <= bit_cnt_r + 1'b1;
      rx_sh_r <= rx_byte;
      if (byte_done)
      begin
        case (st_r)
          ssp_pkg::SSP_ST_ADDR:
          begin
            if (rx_byte[ssp_pkg::DIR_BIT] == ssp_pkg::DIR_WRITE)
            begin
              st_r <= ssp_pkg::SSP_ST_WDATA;
              addr_r <= rx_byte[6:0];
            end
            else
            begin
              st_r <= ssp_pkg::SSP_ST_RDATA;
              burst_r <= (rx_byte[6:0] == ssp_pkg::ADDR_BURST);
              addr_r <= (rx_byte[6:0] == ssp_pkg::ADDR_BURST) ?
                        ssp_pkg::ADDR_BURST_FIRST : rx_byte[6:0];
              bcnt_r <= '0;
            end
          end
          ssp_pkg::SSP_ST_WDATA: st_r <= ssp_pkg::SSP_ST_ADDR;
          ssp_pkg::SSP_ST_RDATA:
          begin
            if (!burst_r)
              st_r <= ssp_pkg::SSP_ST_ADDR;
            else if (bcnt_r == ssp_pkg::BURST_LAST)
              st_r <= ssp_pkg::SSP_ST_LOCK;
            else
            begin
              bcnt_r <= bcnt_r + 1'b1;
              addr_r <= addr_r + 1'b1;
            end
          end
          default: st_r <= ssp_pkg::SSP_ST_ADDR;
        endcase
      end
    end
  end

  // Core requests only ever follow host clocking
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      req_r <= '0;
    else
    begin
      req_r <= '0;
      if (byte_done && !desel)
      begin
        case (st_r)
          ssp_pkg::SSP_ST_ADDR:
          begin
            if (rx_byte[ssp_pkg::DIR_BIT] != ssp_pkg::DIR_WRITE)
            begin
              req_r.rd <= 1'b1;
              req_r.addr <= (rx_byte[6:0] == ssp_pkg::ADDR_BURST) ?
                            ssp_pkg::ADDR_BURST_FIRST : rx_byte[6:0];
            end
          end
          ssp_pkg::SSP_ST_WDATA:
          begin
            req_r.wr <= 1'b1;
            req_r.addr <= addr_r;
            req_r.data <= rx_byte;
          end
          ssp_pkg::SSP_ST_RDATA:
          begin
            if (burst_r && bcnt_r != ssp_pkg::BURST_LAST)
            begin
              req_r.rd <= 1'b1;
              req_r.addr <= addr_r + 1'b1;
            end
          end
          default: req_r <= '0;
        endcase
      end
    end
  end

  assign reg_req = req_r;

  // Read data shift-out; data is latched after the address byte and after each burst byte but the last
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      load_r <= 1'b0;
      tx_sh_r <= '0;
      miso_r <= 1'b0;
    end
    else
    begin
      load_r <= req_r.rd;
      if (desel)
        miso_r <= 1'b0;
      else if (sclk_fall && st_r == ssp_pkg::SSP_ST_RDATA)
        miso_r <= tx_sh_r[7];
      if (load_r)
        tx_sh_r <= reg_rdata;
      else if (sclk_fall && st_r == ssp_pkg::SSP_ST_RDATA)
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
    end
  end

  assign miso = miso_r;
  assign miso_oe = !desel;

  // Motion flag; a new event wins over a clear in the same cycle
  assign y_now = req_r.rd && (req_r.addr == ssp_pkg::ADDR_DELTA_Y);
  assign x_now = req_r.rd && (req_r.addr == ssp_pkg::ADDR_DELTA_X);
  assign wr_mot = req_r.wr && (req_r.addr == ssp_pkg::ADDR_MOTION);
  assign mot_clr = wr_mot || ((rd_y_r || y_now) && (rd_x_r || x_now));

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      motion_n_r <= 1'b1;
      rd_y_r <= 1'b0;
      rd_x_r <= 1'b0;
    end
    else if (mot_evt)
    begin
      motion_n_r <= 1'b0;
      rd_y_r <= 1'b0;
      rd_x_r <= 1'b0;
    end
    else if (mot_clr)
    begin
      motion_n_r <= 1'b1;
      rd_y_r <= 1'b0;
      rd_x_r <= 1'b0;
    end
    else
    begin
      rd_y_r <= rd_y_r || y_now;
      rd_x_r <= rd_x_r || x_now;
    end
  end

  assign motion_n = motion_n_r;

  ssp_pwr_mgr #(
    .DOWN1(DOWN1),
    .DOWN2(DOWN2),
    .DOWN3(DOWN3)
  ) u_pwr (
    .core_clk(core_clk),
    .rst(rst),
    .mot_evt(mot_evt),
    .pwr_mode(pwr_mode),
    .led_on(led_on)
  );

  chk_miso_hiz: assert property (@(posedge core_clk) disable iff (rst)
    (desel && $past(desel)) |-> !miso_oe && !miso && !sclk_rise && !sclk_fall)
    else $error("Port active while deselected");

  chk_deselect_abort: assert property (@(posedge core_clk) disable iff (rst)
    $rose(desel) |=> st_r == ssp_pkg::SSP_ST_ADDR && bit_cnt_r == '0 && !burst_r)
    else $error("Deselect did not reset the port");

  chk_slave_only: assert property (@(posedge core_clk) disable iff (rst)
    (reg_req.rd || reg_req.wr) |-> $past(sclk_rise) && !$past(desel))
    else $error("Request without host clocking");

  chk_write_dir: assert property (@(posedge core_clk) disable iff (rst)
    reg_req.wr |-> $past(st_r) == ssp_pkg::SSP_ST_WDATA && reg_req.data == $past(rx_byte))
    else $error("Write not formed from data byte");

  chk_burst_lock: assert property (@(posedge core_clk) disable iff (rst)
    st_r == ssp_pkg::SSP_ST_LOCK |=> !reg_req.rd && !reg_req.wr && !$changed(bit_cnt_r))
    else $error("Port used before deselect ended burst");

  chk_miso_fall: assert property (@(posedge core_clk) disable iff (rst)
    ($changed(miso) && !desel && !$past(desel)) |-> $past(sclk_fall))
    else $error("MISO changed off a falling edge");

  chk_motion_set: assert property (@(posedge core_clk) disable iff (rst)
    mot_evt |=> !motion_n ##1 (!motion_n || $past(mot_clr)))
    else $error("Motion alert not raised");

  chk_motion_clear: assert property (@(posedge core_clk) disable iff (rst)
    (wr_mot && !mot_evt) |=> motion_n && !rd_y_r && !rd_x_r)
    else $error("Motion write did not clear alert");

  chk_read_load: assert property (@(posedge core_clk) disable iff (rst)
    reg_req.rd |=> ##1 tx_sh_r == $past(reg_rdata))
    else $error("Read data not latched");

endmodule
